// >>> pkg/alu8_pkg.sv
// constants, types and address decode shared by the alu block
package alu8_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPND = 8'h04;
    localparam logic [7:0] OFS_IMM = 8'h08;
    localparam logic [7:0] OFS_ACC = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // operation constants
    localparam logic [7:0] DA_ADD_LO = 8'h06;
    localparam logic [7:0] DA_ADD_HI = 8'h60;
    localparam logic [7:0] DA_ADD_BOTH = 8'h66;
    localparam logic [7:0] DA_SUB_LO = 8'hfa;
    localparam logic [7:0] DA_SUB_HI = 8'ha0;
    localparam logic [7:0] DA_SUB_BOTH = 8'h9a;
    localparam logic [7:0] DA_NONE = 8'h00;
    localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [3:0] DA_SUB_H_LIM = 4'h6;
    localparam logic [7:0] INC_OVF_VAL = 8'h7f;
    localparam logic [7:0] DEC_OVF_VAL = 8'h80;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int CTRL_W = 5;

    typedef enum logic [3:0] {
        OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUBTRACT_WITH_BORROW, OP_COMPARE_OP,
        OP_AND, OP_OR, OP_XOR, OP_INC, OP_DEC, OP_NEGATE_ACCUMULATOR,
        OP_DECIMAL_ADJUST, OP_INVERT_CARRY_FLAG, OP_FORCE_CARRY_FLAG
    } alu8_op_t;

    typedef struct packed {
        logic imm;
        alu8_op_t op;
    } alu8_ctrl_t;

    typedef struct packed {
        logic s;
        logic z;
        logic r5;
        logic h;
        logic r3;
        logic pv;
        logic n;
        logic c;
    } alu8_flags_t;

    typedef struct packed {
        logic [7:0] r;
        logic h;
        logic v;
        logic c;
    } alu8_arith_t;

    typedef enum logic [2:0] {SEL_CTRL, SEL_OPND, SEL_IMM, SEL_ACC, SEL_FLAGS, SEL_NONE} alu8_sel_t;

    function automatic alu8_sel_t reg_sel(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CTRL: reg_sel = SEL_CTRL;
            OFS_OPND: reg_sel = SEL_OPND;
            OFS_IMM: reg_sel = SEL_IMM;
            OFS_ACC: reg_sel = SEL_ACC;
            OFS_FLAGS: reg_sel = SEL_FLAGS;
            default: reg_sel = SEL_NONE;
        endcase
    endfunction
endpackage

// >>> rtl/alu8_axil_slave.sv
// axi4-lite slave front end: handshakes, decode of responses, output flops
`timescale 1ns/100ps
module alu8_axil_slave
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // write channels
    input wire logic [alu8_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [alu8_pkg::DATA_W-1:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    // read channels
    input wire logic [alu8_pkg::ADDR_W-1:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [alu8_pkg::DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    // register file side
    output logic wr_en_o,
    output logic [alu8_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [alu8_pkg::DATA_W-1:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    output logic [alu8_pkg::ADDR_W-1:0] rd_addr_o,
    input wire logic [alu8_pkg::DATA_W-1:0] rd_data_i
);
    logic aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic [alu8_pkg::ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
    logic [alu8_pkg::DATA_W-1:0] w_data_ff, nxt_w_data;
    logic [3:0] w_strb_ff, nxt_w_strb;
    logic awready_ff, nxt_awready, wready_ff, nxt_wready;
    logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
    logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic [alu8_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
    logic do_wr;

    // address and data may arrive in either order; the write fires once both are held
    always_comb
    begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_strb = w_strb_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        do_wr = aw_held_ff && w_held_ff && !bvalid_ff;
        if (awvalid_i && awready_ff)
        begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = awaddr_i;
        end
        if (wvalid_i && wready_ff)
        begin
            nxt_w_held = 1'b1;
            nxt_w_data = wdata_i;
            nxt_w_strb = wstrb_i;
        end
        if (bvalid_ff && bready_i)
            nxt_bvalid = 1'b0;
        if (do_wr)
        begin
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = (alu8_pkg::reg_sel(aw_addr_ff) == alu8_pkg::SEL_NONE) ?
                        alu8_pkg::RESP_SLVERR : alu8_pkg::RESP_OKAY;
        end
        nxt_awready = !nxt_aw_held && !nxt_bvalid;
        nxt_wready = !nxt_w_held && !nxt_bvalid;
    end

    // one read at a time; data captured on the address handshake
    always_comb
    begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && rready_i)
            nxt_rvalid = 1'b0;
        if (arvalid_i && arready_ff)
        begin
            nxt_rvalid = 1'b1;
            nxt_rdata = rd_data_i;
            nxt_rresp = (alu8_pkg::reg_sel(araddr_i) == alu8_pkg::SEL_NONE) ?
                        alu8_pkg::RESP_SLVERR : alu8_pkg::RESP_OKAY;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= 4'h0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= alu8_pkg::RESP_OKAY;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= alu8_pkg::RESP_OKAY;
        end
        else
        begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_strb_ff <= nxt_w_strb;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            arready_ff <= nxt_arready;
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    assign awready_o = awready_ff;
    assign wready_o = wready_ff;
    assign bvalid_o = bvalid_ff;
    assign bresp_o = bresp_ff;
    assign arready_o = arready_ff;
    assign rvalid_o = rvalid_ff;
    assign rdata_o = rdata_ff;
    assign rresp_o = rresp_ff;
    assign wr_en_o = do_wr;
    assign wr_addr_o = aw_addr_ff;
    assign wr_data_o = w_data_ff;
    assign wr_strb_o = w_strb_ff;
    assign rd_addr_o = araddr_i;
endmodule

// >>> rtl/alu8_top.sv
// eight-bit arithmetic and logic unit with its register file on axi4-lite
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module alu8_top
#(
    parameter int ADDR_W = alu8_pkg::ADDR_W
)
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [alu8_pkg::DATA_W-1:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [alu8_pkg::DATA_W-1:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [alu8_pkg::DATA_W-1:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    alu8_pkg::alu8_ctrl_t ctrl_ff, nxt_ctrl, wr_ctrl;
    logic [7:0] opnd_ff, nxt_opnd, imm_ff, nxt_imm, acc_ff, nxt_acc;
    alu8_pkg::alu8_flags_t flags_ff, nxt_flags;
    logic [7:0] op_acc, op_opnd, src, corr;
    alu8_pkg::alu8_flags_t op_flags;
    alu8_pkg::alu8_arith_t ar;
    logic fix_lo, fix_hi, da_h;

    function automatic alu8_pkg::alu8_arith_t add8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] hs;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        add8.r = s[7:0];
        add8.h = hs[4];
        add8.c = s[8];
        add8.v = (a[7] == b[7]) && (s[7] != a[7]);
    endfunction

    // borrow out of bit 7 is the carry; borrow out of the low nibble is the half-carry
    function automatic alu8_pkg::alu8_arith_t sub8(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] hs;
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        hs = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        sub8.r = s[7:0];
        sub8.h = hs[4];
        sub8.c = s[8];
        sub8.v = (a[7] != b[7]) && (s[7] != a[7]);
    endfunction

    function automatic alu8_pkg::alu8_flags_t arith_flags(input alu8_pkg::alu8_arith_t x, input logic sub);
        arith_flags = '0;
        arith_flags.s = x.r[7];
        arith_flags.z = (x.r == alu8_pkg::ZERO_BYTE);
        arith_flags.h = x.h;
        arith_flags.pv = x.v;
        arith_flags.n = sub;
        arith_flags.c = x.c;
    endfunction

    // parity flag reads one for an even count of ones
    function automatic alu8_pkg::alu8_flags_t logic_flags(input logic [7:0] r, input logic h);
        logic_flags = '0;
        logic_flags.s = r[7];
        logic_flags.z = (r == alu8_pkg::ZERO_BYTE);
        logic_flags.h = h;
        logic_flags.pv = ~^r;
    endfunction

    assign wr_ctrl = alu8_pkg::alu8_ctrl_t'(wr_data[alu8_pkg::CTRL_W-1:0]);

    // operation of the opcode being written, computed from the current state
    always_comb
    begin
        op_acc = acc_ff;
        op_opnd = opnd_ff;
        op_flags = flags_ff;
        ar = '0;
        corr = alu8_pkg::DA_NONE;
        fix_lo = 1'b0;
        fix_hi = 1'b0;
        da_h = 1'b0;
        src = wr_ctrl.imm ? imm_ff : opnd_ff;
        case (wr_ctrl.op)
            alu8_pkg::OP_ADD, alu8_pkg::OP_ADD_CARRY:
            begin
                ar = add8(acc_ff, src, (wr_ctrl.op == alu8_pkg::OP_ADD_CARRY) && flags_ff.c);
                op_acc = ar.r;
                op_flags = arith_flags(ar, 1'b0);
            end
            alu8_pkg::OP_SUB, alu8_pkg::OP_SUBTRACT_WITH_BORROW, alu8_pkg::OP_COMPARE_OP:
            begin
                ar = sub8(acc_ff, src, (wr_ctrl.op == alu8_pkg::OP_SUBTRACT_WITH_BORROW) && flags_ff.c);
                if (wr_ctrl.op != alu8_pkg::OP_COMPARE_OP)
                    op_acc = ar.r;
                op_flags = arith_flags(ar, 1'b1);
            end
            alu8_pkg::OP_AND:
            begin
                op_acc = acc_ff & src;
                op_flags = logic_flags(acc_ff & src, 1'b1);
            end
            alu8_pkg::OP_OR:
            begin
                op_acc = acc_ff | src;
                op_flags = logic_flags(acc_ff | src, 1'b0);
            end
            alu8_pkg::OP_XOR:
            begin
                op_acc = acc_ff ^ src;
                op_flags = logic_flags(acc_ff ^ src, 1'b0);
            end
            // increment and decrement work on the register operand, never the immediate
            alu8_pkg::OP_INC:
            begin
                ar = add8(opnd_ff, alu8_pkg::ONE_BYTE, 1'b0);
                op_opnd = ar.r;
                op_flags = arith_flags(ar, 1'b0);
                op_flags.pv = (opnd_ff == alu8_pkg::INC_OVF_VAL);
                op_flags.c = flags_ff.c;
            end
            alu8_pkg::OP_DEC:
            begin
                ar = sub8(opnd_ff, alu8_pkg::ONE_BYTE, 1'b0);
                op_opnd = ar.r;
                op_flags = arith_flags(ar, 1'b1);
                op_flags.pv = (opnd_ff == alu8_pkg::DEC_OVF_VAL);
                op_flags.c = flags_ff.c;
            end
            alu8_pkg::OP_NEGATE_ACCUMULATOR:
            begin
                ar = sub8(alu8_pkg::ZERO_BYTE, acc_ff, 1'b0);
                op_acc = ar.r;
                op_flags = arith_flags(ar, 1'b1);
                op_flags.pv = (acc_ff == alu8_pkg::DEC_OVF_VAL);
                op_flags.c = (acc_ff != alu8_pkg::ZERO_BYTE);
            end
            alu8_pkg::OP_DECIMAL_ADJUST:
            begin
                if (!flags_ff.n)
                begin
                    fix_lo = (acc_ff[3:0] > alu8_pkg::BCD_DIGIT_MAX) || flags_ff.h;
                    fix_hi = (acc_ff > alu8_pkg::BCD_BYTE_MAX) || flags_ff.c;
                    da_h = acc_ff[3:0] > alu8_pkg::BCD_DIGIT_MAX;
                    corr = (fix_lo && fix_hi) ? alu8_pkg::DA_ADD_BOTH :
                           fix_hi ? alu8_pkg::DA_ADD_HI :
                           fix_lo ? alu8_pkg::DA_ADD_LO : alu8_pkg::DA_NONE;
                end
                else
                begin
                    // only the prior flags steer the subtract set; nibble values are then in range
                    fix_lo = flags_ff.h;
                    fix_hi = flags_ff.c;
                    da_h = flags_ff.h && (acc_ff[3:0] < alu8_pkg::DA_SUB_H_LIM);
                    corr = (fix_lo && fix_hi) ? alu8_pkg::DA_SUB_BOTH :
                           fix_hi ? alu8_pkg::DA_SUB_HI :
                           fix_lo ? alu8_pkg::DA_SUB_LO : alu8_pkg::DA_NONE;
                end
                op_acc = acc_ff + corr;
                op_flags = logic_flags(acc_ff + corr, da_h);
                op_flags.n = flags_ff.n;
                op_flags.c = fix_hi;
            end
            alu8_pkg::OP_INVERT_CARRY_FLAG:
            begin
                op_flags.c = ~flags_ff.c;
                op_flags.n = 1'b0;
            end
            alu8_pkg::OP_FORCE_CARRY_FLAG:
            begin
                op_flags.c = 1'b1;
                op_flags.n = 1'b0;
                op_flags.h = 1'b0;
            end
            default:
            begin
                op_acc = acc_ff;
            end
        endcase
    end

    // register writes; writing the control register also executes its opcode
    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_opnd = opnd_ff;
        nxt_imm = imm_ff;
        nxt_acc = acc_ff;
        nxt_flags = flags_ff;
        if (wr_en && wr_strb[0])
        begin
            case (alu8_pkg::reg_sel(wr_addr))
                alu8_pkg::SEL_CTRL:
                begin
                    nxt_ctrl = wr_ctrl;
                    nxt_acc = op_acc;
                    nxt_opnd = op_opnd;
                    nxt_flags = op_flags;
                end
                alu8_pkg::SEL_OPND: nxt_opnd = wr_data[7:0];
                alu8_pkg::SEL_IMM: nxt_imm = wr_data[7:0];
                alu8_pkg::SEL_ACC: nxt_acc = wr_data[7:0];
                alu8_pkg::SEL_FLAGS:
                begin
                    nxt_flags = alu8_pkg::alu8_flags_t'(wr_data[7:0]);
                    nxt_flags.r5 = 1'b0;
                    nxt_flags.r3 = 1'b0;
                end
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
        begin
            ctrl_ff <= '0;
            opnd_ff <= alu8_pkg::RST_BYTE;
            imm_ff <= alu8_pkg::RST_BYTE;
            acc_ff <= alu8_pkg::RST_BYTE;
            flags_ff <= '0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            opnd_ff <= nxt_opnd;
            imm_ff <= nxt_imm;
            acc_ff <= nxt_acc;
            flags_ff <= nxt_flags;
        end
    end

    // read mux; unused upper bits read zero
    always_comb
    begin
        rd_data = '0;
        case (alu8_pkg::reg_sel(rd_addr))
            alu8_pkg::SEL_CTRL: rd_data[alu8_pkg::CTRL_W-1:0] = ctrl_ff;
            alu8_pkg::SEL_OPND: rd_data[7:0] = opnd_ff;
            alu8_pkg::SEL_IMM: rd_data[7:0] = imm_ff;
            alu8_pkg::SEL_ACC: rd_data[7:0] = acc_ff;
            alu8_pkg::SEL_FLAGS: rd_data[7:0] = flags_ff;
            default: rd_data = '0;
        endcase
    end

    alu8_axil_slave u_slave
    (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .awaddr_i(S_AXI_AWADDR_I),
        .awvalid_i(S_AXI_AWVALID_I),
        .awready_o(S_AXI_AWREADY_O),
        .wdata_i(S_AXI_WDATA_I),
        .wstrb_i(S_AXI_WSTRB_I),
        .wvalid_i(S_AXI_WVALID_I),
        .wready_o(S_AXI_WREADY_O),
        .bresp_o(S_AXI_BRESP_O),
        .bvalid_o(S_AXI_BVALID_O),
        .bready_i(S_AXI_BREADY_I),
        .araddr_i(S_AXI_ARADDR_I),
        .arvalid_i(S_AXI_ARVALID_I),
        .arready_o(S_AXI_ARREADY_O),
        .rdata_o(S_AXI_RDATA_O),
        .rresp_o(S_AXI_RRESP_O),
        .rvalid_o(S_AXI_RVALID_O),
        .rready_i(S_AXI_RREADY_I),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data)
    );
endmodule

// >>> testbench/alu8_chk.sv
// bus timing checker bound to the alu top
`timescale 1ns/100ps
module alu8_chk
(
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RESET_N_I,
    // write handshakes
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WVALID_I,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // read channel
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic [1:0] S_AXI_RRESP_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    logic ar_go;
    logic aw_go;
    logic bad_addr;
    assign ar_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    // both channels offered together by the bench, so one joint handshake
    assign aw_go = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    assign bad_addr = S_AXI_ARADDR_I > 8'h10 || S_AXI_ARADDR_I[1:0] != 2'h0;
    chk_read_answer: assert property (ar_go |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read answer late");
    chk_read_upper: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
        else $error("read upper bits set");
    chk_read_slverr: assert property (ar_go && bad_addr |=> S_AXI_RRESP_O == 2'h2 && S_AXI_RDATA_O == 32'h0)
        else $error("unmapped read answered");
    chk_read_okay: assert property (ar_go && !bad_addr |=> S_AXI_RRESP_O == 2'h0)
        else $error("mapped read refused");
    chk_read_release: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O && S_AXI_ARREADY_O)
        else $error("read not released");
    chk_write_answer: assert property (aw_go |=> !S_AXI_BVALID_O ##1 S_AXI_BVALID_O)
        else $error("write answer mistimed");
    chk_write_blocked: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken during answer");
    chk_write_release: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O && S_AXI_AWREADY_O)
        else $error("write not released");
    cover property (ar_go && bad_addr);
    cover property (aw_go);
    cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
endmodule

// >>> testbench/alu8_top_tb.sv
// self-checking bench for the alu block
`timescale 1ns/100ps
module alu8_top_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int err_count = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    alu8_top u_dut
    (
        .SYS_CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready)
    );
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp(32'(bresp), 32'(er));
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp(rdata, {24'h0, e});
        cmp(32'(rresp), 32'(er));
    endtask
    // the unused operand source gets the inverse, so a wrong source selection shows
    task automatic run_op(input logic [7:0] c, a, o, f, input logic on_opnd, input logic [7:0] er, ef);
        wr(alu8_pkg::OFS_ACC, a, 2'h0);
        wr(alu8_pkg::OFS_OPND, c[4] ? ~o : o, 2'h0);
        wr(alu8_pkg::OFS_IMM, c[4] ? o : ~o, 2'h0);
        wr(alu8_pkg::OFS_FLAGS, f, 2'h0);
        wr(alu8_pkg::OFS_CTRL, c, 2'h0);
        rdchk(on_opnd ? alu8_pkg::OFS_OPND : alu8_pkg::OFS_ACC, er, 2'h0);
        rdchk(alu8_pkg::OFS_FLAGS, ef, 2'h0);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 5; i++)
            rdchk(8'(4 * i), 8'h00, 2'h0);
        rdchk(8'h20, 8'h00, 2'h2);
        wr(8'h14, 8'h5a, 2'h2);
    endtask
    task automatic t_arith;
        run_op(8'h00, 8'h78, 8'h69, 8'h00, 1'h0, 8'he1, 8'h94);
        run_op(8'h10, 8'h3a, 8'hc6, 8'h00, 1'h0, 8'h00, 8'h51);
        run_op(8'h01, 8'h0f, 8'h00, 8'h01, 1'h0, 8'h10, 8'h10);
        run_op(8'h12, 8'h10, 8'h20, 8'h00, 1'h0, 8'hf0, 8'h83);
        run_op(8'h03, 8'h80, 8'h00, 8'h01, 1'h0, 8'h7f, 8'h16);
        run_op(8'h04, 8'h42, 8'h43, 8'h00, 1'h0, 8'h42, 8'h93);
    endtask
    task automatic t_logic;
        run_op(8'h05, 8'hf0, 8'h3c, 8'h03, 1'h0, 8'h30, 8'h14);
        run_op(8'h06, 8'h00, 8'h00, 8'h13, 1'h0, 8'h00, 8'h44);
        run_op(8'h17, 8'hff, 8'h01, 8'h11, 1'h0, 8'hfe, 8'h80);
    endtask
    task automatic t_unary;
        run_op(8'h08, 8'h11, 8'h7f, 8'h03, 1'h1, 8'h80, 8'h95);
        run_op(8'h08, 8'h11, 8'hff, 8'h00, 1'h1, 8'h00, 8'h50);
        run_op(8'h09, 8'h11, 8'h80, 8'h00, 1'h1, 8'h7f, 8'h16);
        run_op(8'h0a, 8'h80, 8'h00, 8'h00, 1'h0, 8'h80, 8'h87);
        run_op(8'h0a, 8'h00, 8'h00, 8'h01, 1'h0, 8'h00, 8'h42);
        run_op(8'h0c, 8'h00, 8'h00, 8'hd7, 1'h0, 8'h00, 8'hd4);
        run_op(8'h0d, 8'h00, 8'h00, 8'hd6, 1'h0, 8'h00, 8'hc5);
    endtask
    task automatic t_daa;
        run_op(8'h0b, 8'h3c, 8'h00, 8'h00, 1'h0, 8'h42, 8'h14);
        run_op(8'h0b, 8'h9a, 8'h00, 8'h00, 1'h0, 8'h00, 8'h55);
        run_op(8'h0b, 8'h12, 8'h00, 8'h01, 1'h0, 8'h72, 8'h05);
        run_op(8'h0b, 8'he9, 8'h00, 8'h13, 1'h0, 8'h83, 8'h83);
        run_op(8'h0b, 8'h0c, 8'h00, 8'h12, 1'h0, 8'h06, 8'h06);
        run_op(8'h0b, 8'hf5, 8'h00, 8'h03, 1'h0, 8'h95, 8'h87);
    endtask
    // spare opcode must leave accumulator and flags alone; a write without strobe bit 0 is dropped
    task automatic t_misc;
        run_op(8'h1e, 8'h5a, 8'h33, 8'hd7, 1'h0, 8'h5a, 8'hd7);
        rdchk(alu8_pkg::OFS_CTRL, 8'h1e, 2'h0);
        wstrb <= 4'he;
        wr(alu8_pkg::OFS_ACC, 8'ha5, 2'h0);
        wstrb <= 4'hf;
        rdchk(alu8_pkg::OFS_ACC, 8'h5a, 2'h0);
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_arith();
        t_logic();
        t_unary();
        t_daa();
        t_misc();
        final_report();
    end
    // whole run needs under a thousand cycles, so this only trips on a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
bind alu8_top alu8_chk u_chk
(
    .SYS_CLK_I(SYS_CLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
    .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
    .S_AXI_RRESP_O(S_AXI_RRESP_O), .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I)
);
